// [src/gpabr_game_port.sv]
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpabr_defs.svh"

// Functional notes
// [R1] Enabled and idle: every axis line is actively driven low.
// [R2] Any write to the status offset while the port is enabled releases axis lines to start measuring.
// [R3] Status bit of an axis is one while its line is released.
// [R4] Line sensed high: drive it low for 1.5 us discharge.
// [R5] After discharge, line stays low and status zero until next start write.
// [R6] Start writes are ignored per axis during its charge and discharge.
// [R7] Status bits 7..4 show button pins B1, B0 of B then A.
// [R8] Status bits 3..0 show axis states: B Y, B X, A Y, A X.
// [R9] With filter enabled, button bit follows pin only after 16 ms stable.
// [R10] Filter off after reset; unfiltered buttons follow the pins directly.
// [R11] Host times how long each axis bit stays one to find position.
// [R12] Host interprets button polarity; device reports raw pin levels.
// [R13] Two game devices, each with X, Y and two buttons.
// [R14] Axis and button inputs pass a two-stage synchroniser first.
module gpabr_game_port
    import gpabr_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Avalon-MM slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Axis lines, index 0 A X, 1 A Y, 2 B X, 3 B Y
    input wire logic [3:0] i_axis_line,
    output logic [3:0] o_axis_line_out,
    output logic [3:0] o_axis_line_oe,
    // Buttons, index 0 A0, 1 A1, 2 B0, 3 B1
    input wire logic [3:0] i_button_inputs
);

    gpabr_avmm_req_t req;
    assign req = '{address: i_avs_address, read: i_avs_read,
                   write: i_avs_write, writedata: i_avs_writedata};

    // One access per two cycles: waitrequest drops for one cycle, then the bus sees it high again
    logic ack;
    wire access = (req.read | req.write) & ~ack;
    wire hit_status = (req.address == `GPABR_OFF_STATUS);
    wire hit_config = (req.address == `GPABR_OFF_CONFIG);
    wire wr_status = access & req.write & hit_status;
    wire wr_config = access & req.write & hit_config;

    logic [7:0] config_reg;
    wire filter_enable = config_reg[`GPABR_CFG_FILTER_BIT];
    wire port_enable = config_reg[`GPABR_CFG_ENABLE_BIT];

    // Synchronisers; only the second stage is used downstream
    logic [3:0] axis_meta, axis_sync, btn_meta, btn_sync;
    always_ff @(posedge i_clk_sys) begin
        axis_meta <= i_axis_line; // [R14]
        axis_sync <= axis_meta;
        btn_meta <= i_button_inputs; // [R14]
        btn_sync <= btn_meta;
    end

    gpabr_axis_state_t axis_state [4];
    logic [7:0] dis_cnt [4];
    logic [3:0] axis_released;
    logic [3:0] btn_filtered;
    logic [20:0] deb_cnt [4];

    localparam logic [7:0] DIS_CYC = 8'(`GPABR_DISCHARGE_CYC);
    localparam logic [20:0] DEB_CYC = 21'(`GPABR_DEBOUNCE_CYC);

    genvar g;
    generate
        for (g = 0; g < `GPABR_NUM_AXES; g++) begin : g_axis
            wire start_ok = wr_status & port_enable & (axis_state[g] == AXIS_HOLD); // [R6]
            wire sensed_high = axis_sync[g];
            gpabr_axis_state_t next_state;
            always_comb begin
                next_state = axis_state[g];
                case (axis_state[g])
                    AXIS_HOLD: begin
                        if (start_ok) begin
                            next_state = AXIS_CHARGE; // [R2]
                        end
                    end
                    AXIS_CHARGE: begin
                        if (sensed_high) begin
                            next_state = AXIS_DISCHARGE; // [R4]
                        end
                    end
                    AXIS_DISCHARGE: begin
                        if (dis_cnt[g] == DIS_CYC - 8'h01) begin
                            next_state = AXIS_HOLD; // [R5]
                        end
                    end
                    default: next_state = AXIS_HOLD;
                endcase
            end
            always_ff @(posedge i_clk_sys) begin
                if (!i_reset_n) begin
                    axis_state[g] <= AXIS_HOLD;
                    dis_cnt[g] <= 8'h00;
                end else begin
                    axis_state[g] <= next_state;
                    dis_cnt[g] <= (axis_state[g] == AXIS_DISCHARGE) ? dis_cnt[g] + 8'h01 : 8'h00;
                end
            end
            // Released only while charging; with the port enabled, hold and discharge both drive low
            assign axis_released[g] = (axis_state[g] == AXIS_CHARGE); // [R3] [R8]
        end
        for (g = 0; g < `GPABR_NUM_BTNS; g++) begin : g_btn
            wire differs = (btn_sync[g] != btn_filtered[g]);
            always_ff @(posedge i_clk_sys) begin
                if (!i_reset_n) begin
                    deb_cnt[g] <= 21'h000000;
                    btn_filtered[g] <= 1'b0;
                end else if (!filter_enable) begin
                    deb_cnt[g] <= 21'h000000;
                    btn_filtered[g] <= btn_sync[g]; // [R10]
                end else if (!differs) begin
                    deb_cnt[g] <= 21'h000000;
                end else if (deb_cnt[g] == DEB_CYC - 21'h000001) begin
                    deb_cnt[g] <= 21'h000000;
                    btn_filtered[g] <= btn_sync[g]; // [R9]
                end else begin
                    deb_cnt[g] <= deb_cnt[g] + 21'h000001;
                end
            end
        end
    endgenerate

    // Status layout: bits 7..4 buttons B1 B0 A1 A0, bits 3..0 axes B Y, B X, A Y, A X
    wire [7:0] status_value = {btn_filtered[3], btn_filtered[2], btn_filtered[1],
                               btn_filtered[0], axis_released}; // [R7] [R8] [R13]
    wire [31:0] next_readdata = hit_status ? {24'h000000, status_value} :
                                hit_config ? {24'h000000, config_reg} : 32'h00000000;

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            config_reg <= `GPABR_CFG_RESET | 8'h02;
            ack <= 1'b0;
            o_avs_readdata <= 32'h00000000;
            o_avs_waitrequest <= 1'b1;
            o_axis_line_out <= 4'h0;
            o_axis_line_oe <= 4'h0;
        end else begin
            ack <= access;
            o_avs_waitrequest <= ~access;
            if (access & req.read) begin
                o_avs_readdata <= next_readdata;
            end
            if (wr_config) begin
                config_reg <= req.writedata[7:0] & 8'h03;
            end
            o_axis_line_out <= 4'h0;
            // Drive low unless charging; disabled port floats the lines
            o_axis_line_oe <= port_enable ? ~axis_released : 4'h0; // [R1]
        end
    end

endmodule : gpabr_game_port
`default_nettype wire

// [src/gpabr_defs.svh]
`ifndef GPABR_DEFS_SVH
`define GPABR_DEFS_SVH

// Register byte addresses
`define GPABR_OFF_STATUS 8'h00
`define GPABR_OFF_CONFIG 8'hf0

// Configuration fields
`define GPABR_CFG_FILTER_BIT 0
`define GPABR_CFG_RESET 8'h00

// Port enable field, set after reset so the lines are held low
`define GPABR_CFG_ENABLE_BIT 1

// Status field positions
`define GPABR_ST_AXIS_LSB 0
`define GPABR_ST_BTN_LSB 4

// Timing
`define GPABR_CLK_MHZ 100
`define GPABR_DISCHARGE_NS 1500
`define GPABR_DISCHARGE_CYC (`GPABR_DISCHARGE_NS * `GPABR_CLK_MHZ / 1000)
`define GPABR_DEBOUNCE_MS 16
`define GPABR_DEBOUNCE_CYC (`GPABR_DEBOUNCE_MS * `GPABR_CLK_MHZ * 1000)

`define GPABR_NUM_AXES 4
`define GPABR_NUM_BTNS 4

`endif

// [src/gpabr_pkg.sv]
`default_nettype none
package gpabr_pkg;

    typedef enum logic [1:0] {
        AXIS_HOLD,
        AXIS_CHARGE,
        AXIS_DISCHARGE
    } gpabr_axis_state_t;

    // Axis pins: 0 first horizontal, 1 first vertical, 2 second horizontal, 3 second vertical
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] out;
    } gpabr_axis_drive_t;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } gpabr_avmm_req_t;

endpackage : gpabr_pkg
`default_nettype wire

// [sim/gpabr_rc_net.sv]
`timescale 1ns/1ps
`default_nettype none
module gpabr_rc_net (
    // Clock and axis pins
    input wire logic i_clk_sys,
    input wire logic [3:0] i_oe,
    // Charge delay per axis, nine bits each
    input wire logic [35:0] i_dly,
    output logic [3:0] o_line
);
    int cnt [4] = '{0, 0, 0, 0};
    always @(posedge i_clk_sys) begin
        for (int k = 0; k < 4; k++) begin
            // Driven low empties the capacitor, released it climbs to the threshold
            cnt[k] <= i_oe[k] ? 0 : cnt[k] + 1;
            o_line[k] <= !i_oe[k] && cnt[k] >= int'(i_dly[k*9 +: 9]);
        end
    end
endmodule : gpabr_rc_net
`default_nettype wire

// [sim/gpabr_props.sv]
`timescale 1ns/1ps
`default_nettype none
module gpabr_props (
    // Top ports
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [3:0] i_axis_line,
    input wire logic [3:0] o_axis_line_out,
    input wire logic [3:0] o_axis_line_oe,
    input wire logic [3:0] i_button_inputs
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    wire logic wr_ok = i_avs_write && i_avs_address == 8'h00 && !o_avs_waitrequest;
    logic [7:0] hi_cnt;
    // Saturates so a long hold never wraps under the discharge length
    always_ff @(posedge i_clk_sys) hi_cnt <= !o_axis_line_oe[0] ? 8'h00 : hi_cnt + 8'(hi_cnt != 8'hff);
    // Mirror of filter and port enable, taken from acknowledged configuration writes
    logic [1:0] cfg_seen;
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cfg_seen <= 2'h2;
        end else if (i_avs_write && i_avs_address == 8'hf0 && !o_avs_waitrequest) begin
            cfg_seen <= i_avs_writedata[1:0];
        end
    end
    sequence s_rd;
        i_avs_read && i_avs_address == 8'h00 && !o_avs_waitrequest;
    endsequence
    a_ack_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("ack too long");
    a_drive_low: assert property (o_axis_line_out == 4'h0)
        else $error("line driven high");
    a_sense_discharge: assert property (cfg_seen[1] && !o_axis_line_oe[0] && i_axis_line[0]
        |-> ##[1:4] o_axis_line_oe[0])
        else $error("no discharge");
    a_discharge_len: assert property ($fell(o_axis_line_oe[0]) |-> hi_cnt >= 8'h96)
        else $error("discharge short");
    a_fall_on_write: assert property ($fell(o_axis_line_oe[3]) && cfg_seen[1] |-> $past(wr_ok))
        else $error("release without start");
    a_start_release: assert property (wr_ok && hi_cnt == 8'hff |=> !o_axis_line_oe[0])
        else $error("start ignored");
    a_status_axes: assert property (s_rd |-> o_avs_readdata[3:0] == ~o_axis_line_oe)
        else $error("axis bits wrong");
    a_status_buttons: assert property (s_rd && !cfg_seen[0]
        |-> o_avs_readdata[7:4] == $past(i_button_inputs, 4))
        else $error("button bits wrong");
endmodule : gpabr_props
bind gpabr_game_port gpabr_props i_props (.*);
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wq;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, got, rdat;
    logic [3:0] line, oe, mask, btn = 4'h0;
    logic [35:0] dly = 36'h0;
    int err_total = 0, compares = 0, cyc = 0, t0, last = 0, seed = 32'h846936f7;
    int done_at [4];
    always #5 clk = ~clk;
    gpabr_game_port i_gpabr_game_port (.i_clk_sys(clk), .i_reset_n(rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .i_axis_line(line), .o_axis_line_out(), .o_axis_line_oe(oe),
        .i_button_inputs(btn));
    gpabr_rc_net i_gpabr_rc_net (.i_clk_sys(clk), .i_oe(oe), .i_dly(dly), .o_line(line));
    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int tol);
        compares++;
        if ((^g === 1'bx) || (tol == 0 ? g !== e : (g < e || g > e + tol))) begin
            err_total++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (wq !== 1'b0);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("idle oe", 4'hf, oe, 0);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, got, 0);
        for (int t = 0; t < 3; t++) begin
            btn <= 4'($random(seed));
            for (int k = 0; k < 4; k++)
                dly[k*9 +: 9] <= 9'($random(seed)) | 9'h040;
            // Long enough for a restarted axis to charge and discharge fully
            repeat (700) @(posedge clk);
            chk("held oe", 4'hf, oe, 0);
            bus(1'b0, 8'h00, 32'h0);
            chk("status", {24'h0, btn, 4'h0}, got, 0);
            if (t == 1) begin
                bus(1'b1, 8'hf0, 32'h3);
                bus(1'b0, 8'hf0, 32'h0);
                chk("config", 32'h3, got, 0);
                btn <= ~btn;
                repeat (50) @(posedge clk);
                bus(1'b0, 8'h00, 32'h0);
                chk("filtered", {24'h0, ~btn, 4'h0}, got, 0);
                bus(1'b1, 8'hf0, 32'h2);
                bus(1'b0, 8'h00, 32'h0);
                chk("unfiltered", {24'h0, btn, 4'h0}, got, 0);
            end
            if (t == 2) begin
                // Kept short so no line charges to its threshold while floating
                bus(1'b1, 8'hf0, 32'h0);
                chk("off oe", 4'h0, oe, 0);
                bus(1'b1, 8'h00, 32'h0);
                bus(1'b1, 8'hf0, 32'h2);
                chk("on oe", 4'hf, oe, 0);
                repeat (160) @(posedge clk);
            end
            bus(1'b1, 8'h00, 32'($random(seed)));
            t0 = cyc;
            mask = 4'hf;
            bus(1'b0, 8'h00, 32'h0);
            chk("charging", 4'hf, got[3:0], 0);
            // Late restart would shift every axis time by about forty cycles
            repeat (40) @(posedge clk);
            bus(1'b1, 8'h00, 32'h0);
            while (mask != 4'h0 && cyc - t0 < 1500) begin
                bus(1'b0, 8'h00, 32'h0);
                for (int k = 0; k < 4; k++)
                    if (mask[k] && !got[k]) begin
                        done_at[k] = cyc - t0;
                        mask[k] = 1'b0;
                        last = k;
                    end
            end
            chk("axes done", 32'h0, 32'(mask), 0);
            // The axis seen last is still discharging, so this start must not reach it
            bus(1'b1, 8'h00, 32'h0);
            bus(1'b0, 8'h00, 32'h0);
            chk("discharge lock", 32'h0, 32'(got[last]), 0);
            for (int k = 0; k < 4; k++)
                chk("axis time", 32'(dly[k*9 +: 9]), done_at[k], 12);
        end
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
